// ### hw/wdw_count_stage.sv
// one 8-bit stage of the watchdog counter, cascaded through carry
// assumes load and inc come from the same clock domain
`timescale 1ns/10ps
module wdw_count_stage (
    input wire logic mclk, // peripheral clock
    input wire logic reset, // async, active high
    input wire logic inc, // count up by one
    input wire logic load, // load wins over inc
    input wire logic [7:0] load_val, // value to load
    output logic [7:0] q, // stage value
    output logic carry // inc while at all ones
);
    logic [7:0] q_d;

    always_comb begin
        carry = inc && (q == wdw_pkg::WDW_BYTE_FULL);
        if (load) begin
            q_d = load_val;
        end else if (inc) begin
            q_d = q + 8'h01;
        end else begin
            q_d = q;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= 8'h00;
        end else begin
            q <= q_d;
        end
    end

    wrap_zero_a: assert property (@(posedge mclk) disable iff (reset)
        carry && !load |=> q == 8'h00)
        else $error("stage did not wrap on carry");

endmodule : wdw_count_stage

// ### hw/wdw_pkg.sv
// package of the windowed watchdog: register map, reset values, states
// assumes one 10 MHz peripheral clock drives every user of this package
package wdw_pkg;

    // ----------------------------------------------------------------
    // register map, byte addresses on the plain register port
    // ----------------------------------------------------------------
    localparam logic [7:0] WDW_OFF_CTRL = 8'h00;
    localparam logic [7:0] WDW_OFF_RELOAD = 8'h04;
    localparam logic [7:0] WDW_OFF_WINDOW = 8'h08;
    localparam logic [7:0] WDW_OFF_SERVICE = 8'h0C;
    localparam logic [7:0] WDW_OFF_STATUS = 8'h10;
    localparam logic [7:0] WDW_OFF_COUNT = 8'h14;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int WDW_CTRL_ENABLE_BIT = 0;
    localparam int WDW_CTRL_PRESCALE_BIT = 1;
    localparam int WDW_CTRL_WINDOW_BIT = 2;
    localparam int WDW_STAT_PREWARN_BIT = 0;
    localparam int WDW_STAT_NMI_BIT = 1;
    localparam int WDW_STAT_RESET_BIT = 2;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] WDW_RELOAD_RST = 8'h00;
    localparam logic [7:0] WDW_WINDOW_RST = 8'h00;
    localparam logic [7:0] WDW_BYTE_ZERO = 8'h00;
    localparam logic [7:0] WDW_BYTE_FULL = 8'hFF;
    localparam logic [5:0] WDW_PREWARN_TICKS = 6'h30;
    localparam int WDW_DIV_FAST = 2;
    localparam int WDW_DIV_SLOW = 128;
    localparam int WDW_PRESCALE_W = 7;

    typedef struct packed {
        logic window_en;
        logic prescale_select;
        logic enable;
    } wdw_ctrl_t;

    localparam wdw_ctrl_t WDW_CTRL_RST = 3'h0;

    typedef enum logic [1:0] {
        WDW_ST_COUNT = 2'b00,
        WDW_ST_PREWARN = 2'b01,
        WDW_ST_RESET = 2'b10
    } wdw_state_t;

endpackage : wdw_pkg

// ### hw/wdw_prescaler.sv
// prescaler of the watchdog: one tick per 2 or per 128 clocks
// assumes run is already gated by enable and debug state
`timescale 1ns/10ps
module wdw_prescaler (
    input wire logic mclk, // peripheral clock
    input wire logic reset, // async, active high
    input wire logic run, // advance the divider
    input wire logic prescale_select, // 0: divide by 2, 1: by 128
    output logic tick // one-cycle count tick
);
    localparam logic [6:0] MASK_FAST = 7'(wdw_pkg::WDW_DIV_FAST - 1);
    localparam logic [6:0] MASK_SLOW = 7'(wdw_pkg::WDW_DIV_SLOW - 1);

    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [6:0] mask;

    always_comb begin
        mask = prescale_select ? MASK_SLOW : MASK_FAST;
        tick = run && ((cnt_q & mask) == mask);
        cnt_d = run ? cnt_q + 7'h01 : cnt_q;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    fast_rate_a: assert property (@(posedge mclk) disable iff (reset)
        (run && !prescale_select) ##1 (run && !prescale_select) |-> tick != $past(tick))
        else $error("fast tick not every second clock");
    slow_gap_a: assert property (@(posedge mclk) disable iff (reset)
        (run && prescale_select && tick) ##1 (run && prescale_select)[*8] |-> !tick)
        else $error("slow tick came too early");

endmodule : wdw_prescaler

// ### hw/wdw_watchdog.sv
// windowed watchdog top: register port, 16-bit counter, prewarning phase
// assumes inputs synchronous to mclk and a master that never waits
// Operation
// - sixteen-bit counter, two cascaded byte stages
// - tick is clock over 2 or 128
// - service loads high byte, clears low byte
// - overflow raises nmi, enters prewarning
// - prewarning lasts 30 hex ticks, then reset
// - service inside window: prewarning, no nmi
// - window spans zero to boundary byte times 256
// - debug mode freezes the counter
// - window above reload shortens the period
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps
module wdw_watchdog (
    input wire logic mclk, // 10 MHz peripheral clock
    input wire logic reset, // async, active high
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // write data
    input wire logic wr_en, // one-cycle write strobe
    input wire logic rd_en, // one-cycle read strobe
    output logic [31:0] rdata, // read data, cycle after rd_en
    input wire logic debug_mode, // high while halted in debug
    output logic timeout_nmi_out, // watchdog nmi, level
    output logic system_reset_out // system reset request, level
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    wdw_pkg::wdw_ctrl_t ctrl_q;
    wdw_pkg::wdw_ctrl_t ctrl_d;
    logic [7:0] reload_high_byte_q;
    logic [7:0] reload_high_byte_d;
    logic [7:0] window_boundary_byte_q;
    logic [7:0] window_boundary_byte_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    wdw_pkg::wdw_state_t state_q;
    wdw_pkg::wdw_state_t state_d;
    logic [5:0] prewarn_cnt_q;
    logic [5:0] prewarn_cnt_d;
    logic nmi_q;
    logic nmi_d;
    logic rst_out_q;
    logic rst_out_d;

    logic run;
    logic tick;
    logic count_tick;
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    logic lo_carry;
    logic hi_carry;
    logic [15:0] watchdog_counter;
    logic service;
    logic in_window;
    logic valid_service;
    logic invalid_service;
    logic overflow;
    logic [7:0] load_hi;

    assign watchdog_counter = {hi_q, lo_q};

    // ----------------------------------------------------------------
    // counting path
    // ----------------------------------------------------------------
    // debug only stops counting; registers stay reachable for the debugger
    assign run = ctrl_q.enable && !debug_mode;
    assign count_tick = tick && (state_q == wdw_pkg::WDW_ST_COUNT);

    wdw_prescaler u_prescaler (
        .mclk(mclk),
        .reset(reset),
        .run(run),
        .prescale_select(ctrl_q.prescale_select),
        .tick(tick)
    );

    // low stage clears on service, high stage takes the reload byte, or the window byte when that is larger and window_en is set
    wdw_count_stage u_stage_lo (
        .mclk(mclk),
        .reset(reset),
        .inc(count_tick),
        .load(valid_service),
        .load_val(wdw_pkg::WDW_BYTE_ZERO),
        .q(lo_q),
        .carry(lo_carry)
    );

    wdw_count_stage u_stage_hi (
        .mclk(mclk),
        .reset(reset),
        .inc(lo_carry),
        .load(valid_service),
        .load_val(load_hi),
        .q(hi_q),
        .carry(hi_carry)
    );

    // ----------------------------------------------------------------
    // service decode and window check
    // ----------------------------------------------------------------
    always_comb begin
        service = wr_en && (addr == wdw_pkg::WDW_OFF_SERVICE);
        // boundary inclusive: a hit on boundary*256 is still too early
        in_window = ctrl_q.window_en &&
                    (watchdog_counter <= {window_boundary_byte_q, wdw_pkg::WDW_BYTE_ZERO});
        // services after prewarning start are ignored
        valid_service = service && (state_q == wdw_pkg::WDW_ST_COUNT) && !in_window;
        invalid_service = service && (state_q == wdw_pkg::WDW_ST_COUNT) && in_window;
        // a service on the overflow edge still counts as in time
        overflow = hi_carry && !valid_service;
        if (ctrl_q.window_en && (window_boundary_byte_q > reload_high_byte_q)) begin
            load_hi = window_boundary_byte_q;
        end else begin
            load_hi = reload_high_byte_q;
        end
    end

    // ----------------------------------------------------------------
    // timeout sequence
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        prewarn_cnt_d = prewarn_cnt_q;
        nmi_d = nmi_q;
        rst_out_d = rst_out_q;
        case (state_q)
            wdw_pkg::WDW_ST_COUNT: begin
                prewarn_cnt_d = 6'h00;
                if (overflow) begin
                    nmi_d = 1'b1;
                    state_d = wdw_pkg::WDW_ST_PREWARN;
                end else if (invalid_service) begin
                    state_d = wdw_pkg::WDW_ST_PREWARN;
                end
            end
            wdw_pkg::WDW_ST_PREWARN: begin
                if (tick) begin
                    prewarn_cnt_d = prewarn_cnt_q + 6'h01;
                    if (prewarn_cnt_q + 6'h01 == wdw_pkg::WDW_PREWARN_TICKS) begin
                        rst_out_d = 1'b1;
                        state_d = wdw_pkg::WDW_ST_RESET;
                    end
                end
            end
            wdw_pkg::WDW_ST_RESET: begin
                // held until the system reset comes back to us
                rst_out_d = 1'b1;
            end
            default: begin
                state_d = wdw_pkg::WDW_ST_COUNT;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= wdw_pkg::WDW_ST_COUNT;
            prewarn_cnt_q <= 6'h00;
            nmi_q <= 1'b0;
            rst_out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            prewarn_cnt_q <= prewarn_cnt_d;
            nmi_q <= nmi_d;
            rst_out_q <= rst_out_d;
        end
    end

    assign timeout_nmi_out = nmi_q;
    assign system_reset_out = rst_out_q;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        reload_high_byte_d = reload_high_byte_q;
        window_boundary_byte_d = window_boundary_byte_q;
        rdata_d = 32'h0000_0000;
        if (wr_en) begin
            case (addr)
                wdw_pkg::WDW_OFF_CTRL: begin
                    ctrl_d.enable = wdata[wdw_pkg::WDW_CTRL_ENABLE_BIT];
                    ctrl_d.prescale_select = wdata[wdw_pkg::WDW_CTRL_PRESCALE_BIT];
                    ctrl_d.window_en = wdata[wdw_pkg::WDW_CTRL_WINDOW_BIT];
                end
                wdw_pkg::WDW_OFF_RELOAD: begin
                    reload_high_byte_d = wdata[7:0];
                end
                wdw_pkg::WDW_OFF_WINDOW: begin
                    window_boundary_byte_d = wdata[7:0];
                end
                default: begin
                    ctrl_d = ctrl_q;
                end
            endcase
        end
        if (rd_en) begin
            case (addr)
                wdw_pkg::WDW_OFF_CTRL: begin
                    rdata_d[wdw_pkg::WDW_CTRL_ENABLE_BIT] = ctrl_q.enable;
                    rdata_d[wdw_pkg::WDW_CTRL_PRESCALE_BIT] = ctrl_q.prescale_select;
                    rdata_d[wdw_pkg::WDW_CTRL_WINDOW_BIT] = ctrl_q.window_en;
                end
                wdw_pkg::WDW_OFF_RELOAD: begin
                    rdata_d[7:0] = reload_high_byte_q;
                end
                wdw_pkg::WDW_OFF_WINDOW: begin
                    rdata_d[7:0] = window_boundary_byte_q;
                end
                wdw_pkg::WDW_OFF_STATUS: begin
                    rdata_d[wdw_pkg::WDW_STAT_PREWARN_BIT] = (state_q == wdw_pkg::WDW_ST_PREWARN);
                    rdata_d[wdw_pkg::WDW_STAT_NMI_BIT] = nmi_q;
                    rdata_d[wdw_pkg::WDW_STAT_RESET_BIT] = rst_out_q;
                end
                wdw_pkg::WDW_OFF_COUNT: begin
                    rdata_d[15:0] = watchdog_counter;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q <= wdw_pkg::WDW_CTRL_RST;
            reload_high_byte_q <= wdw_pkg::WDW_RELOAD_RST;
            window_boundary_byte_q <= wdw_pkg::WDW_WINDOW_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            reload_high_byte_q <= reload_high_byte_d;
            window_boundary_byte_q <= window_boundary_byte_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    count_step_a: assert property (
        count_tick && !service |=> watchdog_counter == $past(watchdog_counter) + 16'h0001)
        else $error("counter did not advance by one on tick");

    service_load_a: assert property (
        valid_service |=> watchdog_counter == {$past(load_hi), 8'h00})
        else $error("service did not reload the counter");

    overflow_nmi_a: assert property (
        (state_q == wdw_pkg::WDW_ST_COUNT) && overflow
        |=> nmi_q && (state_q == wdw_pkg::WDW_ST_PREWARN))
        else $error("overflow did not raise nmi and prewarning");

    prewarn_end_a: assert property (
        $rose(rst_out_q) |-> $past(prewarn_cnt_q) == 6'h2F && $past(tick))
        else $error("reset not after thirty hex prewarning ticks");

    prewarn_len_a: assert property (
        (state_q == wdw_pkg::WDW_ST_PREWARN) && tick && prewarn_cnt_q == 6'h2F |=> rst_out_q)
        else $error("reset missing at end of prewarning");

    invalid_svc_a: assert property (
        invalid_service && !nmi_q |=> !nmi_q && (state_q == wdw_pkg::WDW_ST_PREWARN))
        else $error("invalid service handled wrongly");

    window_edge_a: assert property (
        service && (state_q == wdw_pkg::WDW_ST_COUNT) && ctrl_q.window_en
        && watchdog_counter == {window_boundary_byte_q, 8'h00} |=> state_q == wdw_pkg::WDW_ST_PREWARN)
        else $error("service on window boundary accepted");

    debug_hold_a: assert property (
        debug_mode && !service |=> $stable(watchdog_counter))
        else $error("counter moved in debug mode");

    window_load_a: assert property (
        valid_service && ctrl_q.window_en && window_boundary_byte_q > reload_high_byte_q
        |=> hi_q == $past(window_boundary_byte_q))
        else $error("window byte not used as reload");

    prewarn_keep_a: assert property (
        state_q == wdw_pkg::WDW_ST_PREWARN |=> state_q != wdw_pkg::WDW_ST_COUNT)
        else $error("prewarning was cancelled");

    read_answer_a: assert property (
        rd_en && addr == wdw_pkg::WDW_OFF_RELOAD && !wr_en |=> rdata == {24'h000000, $past(reload_high_byte_q)})
        else $error("reload register read back wrong");

endmodule : wdw_watchdog

// ### verification/tb_windowed_watchdog_timer.sv
// testbench of the windowed watchdog: register table, tick rates, timeout, window
// assumes the design's register map and the 10 MHz clock from its package
`timescale 1ns/10ps
module tb_windowed_watchdog_timer;
    localparam int LIMIT = 10000;
    localparam logic [7:0] O_CTRL = wdw_pkg::WDW_OFF_CTRL;
    localparam logic [7:0] O_REL = wdw_pkg::WDW_OFF_RELOAD;
    localparam logic [7:0] O_WIN = wdw_pkg::WDW_OFF_WINDOW;
    localparam logic [7:0] O_SVC = wdw_pkg::WDW_OFF_SERVICE;
    localparam logic [7:0] O_STAT = wdw_pkg::WDW_OFF_STATUS;
    localparam logic [7:0] O_CNT = wdw_pkg::WDW_OFF_COUNT;
    localparam int PW_CYC = wdw_pkg::WDW_DIV_FAST * int'(wdw_pkg::WDW_PREWARN_TICKS);

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
    } wdw_row_t;

    logic mclk, reset, wr_en, rd_en, debug_mode;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic timeout_nmi_out, system_reset_out;
    int n_mismatch, compares, pw_cnt;
    int cyc = 0;

    // --------------------------------------------------------------
    // register table rows: reads of reset values, then writes and reads with expected data
    // --------------------------------------------------------------
    wdw_row_t rows [0:21] = '{
        '{1'b0, O_CTRL, 32'h0, 32'h0}, '{1'b0, O_REL, 32'h0, 32'h0},
        '{1'b0, O_WIN, 32'h0, 32'h0}, '{1'b0, O_STAT, 32'h0, 32'h0},
        '{1'b0, O_CNT, 32'h0, 32'h0}, '{1'b0, O_SVC, 32'h0, 32'h0},
        '{1'b1, O_CTRL, 32'h6, 32'h0}, '{1'b0, O_CTRL, 32'h0, 32'h6},
        '{1'b1, O_CTRL, 32'h0, 32'h0}, '{1'b1, O_REL, 32'hFFFFFFAB, 32'h0},
        '{1'b0, O_REL, 32'h0, 32'hAB}, '{1'b1, O_WIN, 32'h5A, 32'h0},
        '{1'b0, O_WIN, 32'h0, 32'h5A}, '{1'b1, 8'h20, 32'hFFFFFFFF, 32'h0},
        '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b1, O_STAT, 32'h7, 32'h0},
        '{1'b0, O_STAT, 32'h0, 32'h0}, '{1'b1, O_CNT, 32'h1234, 32'h0},
        '{1'b0, O_CNT, 32'h0, 32'h0}, '{1'b1, O_SVC, 32'h0, 32'h0},
        '{1'b0, O_CNT, 32'h0, 32'hAB00}, '{1'b0, O_CTRL, 32'h0, 32'h0}
    };

    wdw_watchdog dut_u (
        .mclk(mclk),
        .reset(reset),
        .addr(addr),
        .wdata(wdata),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rdata(rdata),
        .debug_mode(debug_mode),
        .timeout_nmi_out(timeout_nmi_out),
        .system_reset_out(system_reset_out)
    );

    always #50 mclk = ~mclk;

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            conclude();
        end
    end

    // cycles spent with the warning raised but the reset not yet out
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pw_cnt <= 0;
        end else if (timeout_nmi_out === 1'b1 && system_reset_out !== 1'b1) begin
            pw_cnt <= pw_cnt + 1;
        end
    end

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task conclude;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask : rd

    task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(name, v, exp);
    endtask : rd_chk

    task do_reset;
        @(posedge mclk);
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        check("nmi_after_reset", {31'h0, timeout_nmi_out}, 32'h0);
        check("rst_after_reset", {31'h0, system_reset_out}, 32'h0);
    endtask : do_reset

    // bounded wait for the system reset; gives cycles since t0
    task wait_rst(input int t0, output int d);
        int n;
        n = 0;
        while (system_reset_out !== 1'b1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        d = cyc - t0;
    endtask : wait_rst

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        logic [31:0] a, b;
        int t0, d, n;
        mclk = 1'b0;
        reset = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        debug_mode = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        n_mismatch = 0;
        compares = 0;
        do_reset();
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].data);
            end else begin
                rd_chk("table_read", rows[i].addr, rows[i].exp);
            end
        end
        // sample edges are the gap plus two cycles apart: 600 and 1280, whole tick periods
        wr(O_CTRL, 32'h1);
        wr(O_REL, 32'h0);
        wr(O_SVC, 32'h0);
        rd(O_CNT, a);
        repeat (598) @(posedge mclk);
        rd(O_CNT, b);
        check("rate_div2_carry", b - a, 32'd300);
        wr(O_CTRL, 32'h3);
        rd(O_CNT, a);
        repeat (1278) @(posedge mclk);
        rd(O_CNT, b);
        check("rate_div128", b - a, 32'd10);
        @(posedge mclk);
        debug_mode <= 1'b1;
        rd(O_CNT, a);
        repeat (297) @(posedge mclk);
        rd(O_CNT, b);
        check("debug_freeze", b - a, 32'h0);
        @(posedge mclk);
        debug_mode <= 1'b0;
        // overflow from FF00 at divide by 2: 512 cycles
        wr(O_CTRL, 32'h1);
        wr(O_REL, 32'hFF);
        wr(O_SVC, 32'h0);
        @(negedge mclk);
        t0 = cyc;
        n = 0;
        while (timeout_nmi_out !== 1'b1 && n < 600) begin
            @(negedge mclk);
            n++;
        end
        d = cyc - t0;
        check("overflow_period", 32'(d >= 511 && d <= 512), 32'h1);
        check("reset_waits", {31'h0, system_reset_out}, 32'h0);
        wr(O_SVC, 32'h0);
        rd_chk("status_prewarn_nmi", O_STAT, 32'h3);
        wait_rst(t0, d);
        check("prewarn_length", 32'(pw_cnt), 32'(PW_CYC));
        rd_chk("status_reset", O_STAT, 32'h6);
        do_reset();
        // window above reload, then a refresh exactly on the boundary
        wr(O_REL, 32'h20);
        wr(O_SVC, 32'h0);
        wr(O_REL, 32'h05);
        wr(O_WIN, 32'h18);
        wr(O_CTRL, 32'h4);
        wr(O_SVC, 32'h0);
        rd_chk("count_window_load", O_CNT, 32'h1800);
        rd_chk("status_valid", O_STAT, 32'h0);
        wr(O_SVC, 32'h0);
        rd_chk("status_invalid", O_STAT, 32'h1);
        // prewarning stays frozen until enable starts the prescaler
        wr(O_CTRL, 32'h5);
        @(negedge mclk);
        t0 = cyc;
        wait_rst(t0, d);
        check("invalid_reset_time", 32'(d >= PW_CYC - 2 && d <= PW_CYC + 2), 32'h1);
        check("invalid_no_nmi", {31'h0, timeout_nmi_out}, 32'h0);
        conclude();
    end
endmodule : tb_windowed_watchdog_timer
